// *** shared/iqc_pkg.sv ***
// Purpose: Constants and types shared by the interrupt and clock-loss status block.
// Assumes: Registers are reached through a word-wide register port driven by the serial host unit.
// Notes on behaviour
// R1: Interrupt output goes low while any enabled source requests.
// R2: Status snapshot is taken when the line asserts, then frozen.
// R3: With no source requesting, release the line and zero the status.
// R4: Host reads the status register over the serial interface for the cause.
// R5: Sources are core requests, driver disable, serial errors, clock loss, code sums.
// R6: Bits 0 to 3 show halted cores, a0 a1 b0 b1.
// R7: Bits 4 to 7 show core interrupt requests, same order.
// R8: Bit 8 shows drivers disabled, bit 9 a serial error.
// R9: Bit 10 shows the system clock missing.
// R10: Bits 11 and 12 show a bad code sum on channel a or b.
// R11: Clock status bit 8 sets on timing violation, clears on write one.
// R12: Clock status bit 0 latches reference loss, read only.
// R13: Host restores the clock pin, then sets the return request.
// R14: Return request acts on rising edge, self-clears once switched back.
// R15: Return request without clock loss clears at once, no action.
// R16: Host enable bit 2 raises a clock-loss request until the register is read.
// R17: Bits 3 to 6 enable core alerts on clock loss, a0 a1 b0 b1.
// R18: Bit 7 disables output drivers while the clock-missing signal is high.
// R19: Clock-loss alerts hold while missing; cores act once the clock is valid.
// R20: Alert fires on each switch to internal and each requested switch back.
// R21: Status register writes are ignored; reserved bits read zero.
// Notes: Offsets are word addresses on the register port.
package iqc_pkg;
   localparam logic [9:0] IQC_CLK_STAT_ADDR = 10'h1c7;
   localparam logic [9:0] IQC_IRQ_STAT_ADDR = 10'h1d4;
   localparam logic [15:0] IQC_RESET_VALUE = 16'h0000;
   localparam int IQC_NUM_SRC = 13;
   localparam int IQC_BIT_HALT = 0;
   localparam int IQC_BIT_CORE_REQ = 4;
   localparam int IQC_BIT_DRV = 8;
   localparam int IQC_BIT_SERIAL = 9;
   localparam int IQC_BIT_CLK_MISS = 10;
   localparam int IQC_BIT_SUM_A = 11;
   localparam int IQC_BIT_SUM_B = 12;
   localparam int IQC_CB_REF_LOST = 0;
   localparam int IQC_CB_RETURN = 1;
   localparam int IQC_CB_HOST_EN = 2;
   localparam int IQC_CB_CORE_EN = 3;
   localparam int IQC_CB_DRV_OFF = 7;
   localparam int IQC_CB_TIMING = 8;
   localparam logic [15:0] IQC_CLK_WMASK = 16'h00fe;
   localparam int IQC_RELOCK_NS = 25000;
   localparam int IQC_CLK_PERIOD_NS = 5;
   localparam int IQC_RELOCK_CYCLES = IQC_RELOCK_NS / IQC_CLK_PERIOD_NS;

   typedef enum logic [1:0] {
      IQC_IDLE = 2'b01,
      IQC_HELD = 2'b10
   } iqc_line_e;
endpackage

// *** shared/iqc_src_if.sv ***
// Purpose: Carries raw interrupt sources from the top to the collector.
// Assumes: All signals are on the system clock.
// Notes: The top drives every request, and drives the clock-loss request from its host alert.
`timescale 1ns/1ps
`default_nettype none
interface iqc_src_if;
   logic [12:0] req;
   logic [12:0] stat;
   logic active;
   modport collector (input req, output stat, output active);
   modport source (output req, input stat, input active);
endinterface
`default_nettype wire

// *** rtl/iqc_collect.sv ***
// Purpose: Collects sources, drives the interrupt line state and freezes the status snapshot.
// Assumes: Sources are synchronous, active-high levels.
// Notes: The snapshot is the only memory here, so no separate memory module is needed.
`timescale 1ns/1ps
`default_nettype none
module iqc_collect
   import iqc_pkg::*;
(
   input wire logic i_core_clk,
   input wire logic i_sys_rst,
   iqc_src_if.collector src
);
   typedef struct packed {
      iqc_line_e line;
      logic [12:0] snap;
   } iqc_col_s;

   iqc_col_s st_q;
   iqc_col_s st_d;

   always_comb begin
      st_d = st_q;
      unique case (st_q.line)
         IQC_IDLE: begin
            if (|src.req) begin
               st_d.line = IQC_HELD; // R1
               st_d.snap = src.req; // R2
            end
         end
         IQC_HELD: begin
            if (!(|src.req)) begin
               st_d.line = IQC_IDLE; // R3
               st_d.snap = '0; // R3
            end
         end
         default: begin
            st_d.line = IQC_IDLE;
            st_d.snap = '0;
         end
      endcase
   end

   always_ff @(posedge i_core_clk) begin
      if (i_sys_rst) begin
         st_q <= '{line: IQC_IDLE, snap: 13'h0000};
      end else begin
         st_q <= st_d;
      end
   end

   assign src.stat = st_q.snap;
   assign src.active = (st_q.line == IQC_HELD);
endmodule
`default_nettype wire

// *** rtl/iqc_top.sv ***
// Purpose: Interrupt collector and clock-loss status and control registers.
// Assumes: Register port is word-wide with one-cycle read and write strobes on the system clock.
// Notes: Source inputs come from logic on the same clock and are not synchronised.
`timescale 1ns/1ps
`default_nettype none
module iqc_top
   import iqc_pkg::*;
(
   input wire logic i_core_clk,
   input wire logic i_sys_rst,
   input wire logic [9:0] i_reg_addr,
   input wire logic i_reg_wr,
   input wire logic i_reg_rd,
   input wire logic [15:0] i_reg_wdata,
   output logic [15:0] o_reg_rdata,
   input wire logic [3:0] i_core_halted,
   input wire logic [3:0] i_core_request,
   input wire logic i_drv_disabled,
   input wire logic i_serial_error,
   input wire logic i_clock_missing,
   input wire logic i_code_sum_bad_a,
   input wire logic i_code_sum_bad_b,
   input wire logic i_timing_violation,
   input wire logic i_ref_lost_event,
   input wire logic i_switched_back,
   input wire logic i_ext_clock_valid,
   output logic o_return_to_ext_reference,
   output logic [3:0] o_core_alert,
   output logic o_clock_drv_enable,
   output logic o_host_interrupt_out_n
);
   typedef struct packed {
      logic [15:0] clk_reg;
      logic return_pend;
      logic host_alert;
      logic [3:0] core_alert;
      logic miss_prev;
      logic [15:0] rdata;
      logic go_pulse;
   } iqc_top_s;

   iqc_top_s st_q;
   iqc_top_s st_d;
   iqc_src_if src ();

   function automatic logic hit(input logic [9:0] a, input logic [9:0] target);
      hit = (a == target);
   endfunction

   logic wr_clk;
   logic rd_clk;
   logic rd_irq;
   logic miss_rise;
   logic return_rise;
   logic [12:0] sources;

   assign wr_clk = i_reg_wr && hit(i_reg_addr, IQC_CLK_STAT_ADDR);
   assign rd_clk = i_reg_rd && hit(i_reg_addr, IQC_CLK_STAT_ADDR);
   assign rd_irq = i_reg_rd && hit(i_reg_addr, IQC_IRQ_STAT_ADDR);
   assign miss_rise = i_clock_missing && !st_q.miss_prev;
   assign return_rise = wr_clk && i_reg_wdata[IQC_CB_RETURN]
      && !st_q.clk_reg[IQC_CB_RETURN]; // R14

   // The clock-missing source is raised only when the host enable is set, so a disabled
   // clock-loss alert cannot pull the line low.
   always_comb begin
      sources = '0;
      sources[IQC_BIT_HALT +: 4] = i_core_halted; // R6 R5
      sources[IQC_BIT_CORE_REQ +: 4] = i_core_request; // R7
      sources[IQC_BIT_DRV] = i_drv_disabled; // R8
      sources[IQC_BIT_SERIAL] = i_serial_error; // R8
      sources[IQC_BIT_CLK_MISS] = st_q.host_alert; // R9
      sources[IQC_BIT_SUM_A] = i_code_sum_bad_a; // R10
      sources[IQC_BIT_SUM_B] = i_code_sum_bad_b; // R10
   end

   assign src.req = sources;

   iqc_collect u_collect (
      .i_core_clk(i_core_clk),
      .i_sys_rst(i_sys_rst),
      .src(src)
   );

   always_comb begin
      st_d = st_q;
      st_d.miss_prev = i_clock_missing;
      st_d.go_pulse = 1'b0;
      if (wr_clk) begin
         st_d.clk_reg = (st_q.clk_reg & ~IQC_CLK_WMASK) | (i_reg_wdata & IQC_CLK_WMASK);
         st_d.clk_reg[IQC_CB_RETURN] = st_q.clk_reg[IQC_CB_RETURN] || return_rise;
         if (i_reg_wdata[IQC_CB_TIMING]) begin
            st_d.clk_reg[IQC_CB_TIMING] = 1'b0; // R11
         end
      end
      if (i_timing_violation) begin
         st_d.clk_reg[IQC_CB_TIMING] = 1'b1; // R11
      end
      if (return_rise) begin
         if (st_q.clk_reg[IQC_CB_REF_LOST]) begin
            st_d.go_pulse = i_ext_clock_valid; // R14 R13
         end else begin
            st_d.clk_reg[IQC_CB_RETURN] = 1'b0; // R15
         end
      end
      if (st_q.clk_reg[IQC_CB_RETURN] && i_switched_back) begin
         st_d.clk_reg[IQC_CB_RETURN] = 1'b0; // R14
         st_d.clk_reg[IQC_CB_REF_LOST] = 1'b0; // R12
      end
      if (i_ref_lost_event) begin
         st_d.clk_reg[IQC_CB_REF_LOST] = 1'b1; // R12
      end
      // Reading clears the host alert, but a fresh loss in the same cycle keeps it set.
      if (rd_clk) begin
         st_d.host_alert = 1'b0; // R16
      end
      if ((miss_rise || (return_rise && st_q.clk_reg[IQC_CB_REF_LOST])
            || i_clock_missing) && st_q.clk_reg[IQC_CB_HOST_EN]) begin
         st_d.host_alert = 1'b1; // R16 R19 R20
      end
      for (int k = 0; k < 4; k++) begin
         if (!i_clock_missing && i_ext_clock_valid) begin
            st_d.core_alert[k] = 1'b0;
         end
         if ((miss_rise || i_clock_missing || (return_rise && st_q.clk_reg[IQC_CB_REF_LOST]))
               && st_q.clk_reg[IQC_CB_CORE_EN + k]) begin
            st_d.core_alert[k] = 1'b1; // R17 R20
         end
      end
      st_d.rdata = '0;
      if (rd_clk) begin
         st_d.rdata = st_q.clk_reg;
      end else if (rd_irq) begin
         st_d.rdata = {3'h0, src.stat}; // R21 R4
      end
   end

   always_ff @(posedge i_core_clk) begin
      if (i_sys_rst) begin
         st_q <= '0;
      end else begin
         st_q <= st_d;
      end
   end

   assign o_reg_rdata = st_q.rdata;
   assign o_return_to_ext_reference = st_q.go_pulse;
   // Cores see their alert only once the clock pin carries a valid clock.
   assign o_core_alert = st_q.core_alert & {4{i_ext_clock_valid}}; // R19
   assign o_clock_drv_enable = !(st_q.clk_reg[IQC_CB_DRV_OFF] && i_clock_missing); // R18
   assign o_host_interrupt_out_n = !src.active; // R1
endmodule
`default_nettype wire

// *** sim/iqc_props.sv ***
// Purpose: Port checks for the interrupt and clock-loss block.
// Assumes: Bound to iqc_top; reset is synchronous, active high.
// Notes: Internal bits are seen only through read data, so checks tie outputs to inputs.
`timescale 1ns/1ps
`default_nettype none
module iqc_props
   import iqc_pkg::*;
(
   input wire logic i_core_clk,
   input wire logic i_sys_rst,
   input wire logic [9:0] i_reg_addr,
   input wire logic i_reg_wr,
   input wire logic i_reg_rd,
   input wire logic [15:0] i_reg_wdata,
   input wire logic [15:0] o_reg_rdata,
   input wire logic [3:0] i_core_halted,
   input wire logic [3:0] i_core_request,
   input wire logic i_drv_disabled,
   input wire logic i_serial_error,
   input wire logic i_clock_missing,
   input wire logic i_code_sum_bad_a,
   input wire logic i_code_sum_bad_b,
   input wire logic i_ext_clock_valid,
   input wire logic o_return_to_ext_reference,
   input wire logic [3:0] o_core_alert,
   input wire logic o_clock_drv_enable,
   input wire logic o_host_interrupt_out_n
);
   logic src;
   logic rd_map;
   logic ret_req;
   // A host write of the return bit can raise the clock-loss alert with no source pin high.
   assign ret_req = i_reg_wr && i_reg_addr == IQC_CLK_STAT_ADDR
      && i_reg_wdata[IQC_CB_RETURN];
   assign src = |{i_core_halted, i_core_request, i_drv_disabled, i_serial_error,
      i_code_sum_bad_a, i_code_sum_bad_b};
   assign rd_map = i_reg_rd && (i_reg_addr == IQC_CLK_STAT_ADDR || i_reg_addr == IQC_IRQ_STAT_ADDR);
   default clocking @(posedge i_core_clk); endclocking
   default disable iff (i_sys_rst);
   a_irq_on_src: assert property (src |=> !o_host_interrupt_out_n)
      else $error("interrupt line not low after a source request");
   a_irq_has_cause: assert property ($fell(o_host_interrupt_out_n) |->
      $past(src || i_clock_missing) || $past(i_clock_missing, 2) || $past(ret_req, 2))
      else $error("line fell alone");
   a_drv_stays_on: assert property (!i_clock_missing |-> o_clock_drv_enable)
      else $error("drivers off without clock loss");
   a_rdata_idle: assert property (!$past(rd_map) |-> o_reg_rdata == 16'h0000)
      else $error("read data not zero");
   a_rsvd_zero: assert property ($past(i_reg_rd) |-> o_reg_rdata[15:13] == 3'h0)
      else $error("reserved bits not zero");
   a_return_pulse: assert property (o_return_to_ext_reference |=> !o_return_to_ext_reference)
      else $error("return request longer than one cycle");
   a_return_valid: assert property (o_return_to_ext_reference |-> $past(i_ext_clock_valid))
      else $error("return request without a valid clock");
   a_alert_gate: assert property (!i_ext_clock_valid [*2] |-> o_core_alert == 4'h0)
      else $error("core alert without a valid clock");
   a_alert_clears: assert property (!i_clock_missing && i_ext_clock_valid && !ret_req |=>
      o_core_alert == 4'h0) else $error("core alert kept with the clock back");
endmodule
`default_nettype wire

// *** sim/iqc_clk_mgr_model.sv ***
// Purpose: Clock manager stand-in that completes a switch back to the external reference.
// Assumes: The return request is a one-cycle pulse on the system clock.
// Notes: A larger DELAY, up to 255, models a slow relock; only the moment of the answer moves.
`timescale 1ns/1ps
`default_nettype none
module iqc_clk_mgr_model #(
   parameter int DELAY = 4
) (
   input wire logic i_core_clk,
   input wire logic i_sys_rst,
   input wire logic i_return,
   output logic o_switched_back
);
   logic [7:0] cnt_q;
   always_ff @(posedge i_core_clk) begin
      if (i_sys_rst) begin
         cnt_q <= 8'h00;
      end else if (i_return) begin
         cnt_q <= 8'(DELAY);
      end else if (cnt_q != 8'h00) begin
         cnt_q <= cnt_q - 8'h01;
      end
   end
   assign o_switched_back = (cnt_q == 8'h01);
endmodule
`default_nettype wire

// *** sim/irq_and_clock_loss_status_test.sv ***
// Purpose: Register-level test of the interrupt and clock-loss block.
// Assumes: Inputs change 1 ns after the rising edge of a 200 MHz clock.
// Notes: Clock-missing status is exercised on its own since it needs the host enable.
`timescale 1ns/1ps
`default_nettype none
module irq_and_clock_loss_status_test;
   import iqc_pkg::*;
   logic clk = 0, rst = 1, wr = 0, rd = 0, miss = 0, tv = 0, lost = 0, valid = 0;
   logic [9:0] addr = '0;
   logic [15:0] wdata = '0, rdata;
   logic [12:0] src = '0;
   logic back, ret, drv_en, irq_n;
   logic [3:0] alert;
   int n_fail = 0, n_compared = 0, i;
   always #2.5 clk = ~clk;
   iqc_top dut (.i_core_clk(clk), .i_sys_rst(rst), .i_reg_addr(addr), .i_reg_wr(wr),
      .i_reg_rd(rd), .i_reg_wdata(wdata), .o_reg_rdata(rdata), .i_core_halted(src[3:0]),
      .i_core_request(src[7:4]), .i_drv_disabled(src[8]), .i_serial_error(src[9]),
      .i_clock_missing(miss), .i_code_sum_bad_a(src[11]), .i_code_sum_bad_b(src[12]),
      .i_timing_violation(tv), .i_ref_lost_event(lost), .i_switched_back(back),
      .i_ext_clock_valid(valid), .o_return_to_ext_reference(ret), .o_core_alert(alert),
      .o_clock_drv_enable(drv_en), .o_host_interrupt_out_n(irq_n));
   iqc_clk_mgr_model u_mgr (.i_core_clk(clk), .i_sys_rst(rst), .i_return(ret),
      .o_switched_back(back));
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task automatic chk(input string what, input logic [15:0] got, input logic [15:0] exp);
      n_compared++;
      if (got !== exp) begin
         n_fail++;
         $display("Error %s expected %h seen %h", what, exp, got);
      end
   endtask
   // Writes when w is high, else reads and compares against d.
   task automatic acc(input logic w, input logic [9:0] a, input logic [15:0] d);
      addr = a;
      wdata = d;
      wr = w;
      rd = !w;
      cyc(1);
      wr = 1'b0;
      rd = 1'b0;
      if (!w) chk("rdata", rdata, d);
      cyc(1);
   endtask
   task automatic final_report;
      $display("compared %0d mismatched %0d", n_compared, n_fail);
      if (n_fail == 0 && n_compared > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask
   // The tests need well under a thousand cycles; this cuts a hang short.
   initial begin
      #20000;
      n_fail++;
      final_report;
   end
   initial begin
      cyc(16);
      rst = 1'b0;
      acc(0, IQC_CLK_STAT_ADDR, 16'h0000);
      acc(0, IQC_IRQ_STAT_ADDR, 16'h0000);
      for (i = 0; i < 13; i++) begin
         if (i != IQC_BIT_CLK_MISS) begin
            src[i] = 1'b1;
            cyc(2);
            chk("irq_n", 16'(irq_n), 16'h0000);
            src[(i + 1) % 13] = 1'b1;
            acc(0, IQC_IRQ_STAT_ADDR, 16'h0001 << i);
            src = '0;
            cyc(2);
            chk("irq_n", 16'(irq_n), 16'h0001);
            acc(0, IQC_IRQ_STAT_ADDR, 16'h0000);
         end
      end
      acc(1, IQC_IRQ_STAT_ADDR, 16'hffff);
      acc(0, IQC_IRQ_STAT_ADDR, 16'h0000);
      acc(0, 10'h000, 16'h0000);
      acc(1, IQC_CLK_STAT_ADDR, 16'hfffd);
      acc(0, IQC_CLK_STAT_ADDR, 16'h00fc);
      acc(1, IQC_CLK_STAT_ADDR, 16'h00fe);
      acc(0, IQC_CLK_STAT_ADDR, 16'h00fc);
      lost = 1'b1;
      miss = 1'b1;
      cyc(1);
      lost = 1'b0;
      cyc(3);
      chk("drv_en", 16'(drv_en), 16'h0000);
      chk("alert", 16'(alert), 16'h0000);
      chk("irq_n", 16'(irq_n), 16'h0000);
      valid = 1'b1;
      cyc(3);
      chk("alert", 16'(alert), 16'h000f);
      miss = 1'b0;
      cyc(3);
      chk("drv_en", 16'(drv_en), 16'h0001);
      acc(0, IQC_IRQ_STAT_ADDR, 16'h0400);
      chk("irq_n", 16'(irq_n), 16'h0000);
      acc(0, IQC_CLK_STAT_ADDR, 16'h00fd);
      cyc(2);
      chk("irq_n", 16'(irq_n), 16'h0001);
      // Driven by hand: the switch-back pulse and the core alerts stand one cycle only.
      addr = IQC_CLK_STAT_ADDR;
      wdata = 16'h00fe;
      wr = 1'b1;
      cyc(1);
      wr = 1'b0;
      chk("ret", 16'(ret), 16'h0001);
      chk("alert", 16'(alert), 16'h000f);
      cyc(6);
      chk("irq_n", 16'(irq_n), 16'h0000);
      acc(0, IQC_CLK_STAT_ADDR, 16'h00fc);
      tv = 1'b1;
      cyc(1);
      tv = 1'b0;
      acc(0, IQC_CLK_STAT_ADDR, 16'h01fc);
      acc(1, IQC_CLK_STAT_ADDR, 16'h01fc);
      acc(0, IQC_CLK_STAT_ADDR, 16'h00fc);
      final_report;
   end
endmodule
bind iqc_top iqc_props u_props (.i_core_clk, .i_sys_rst, .i_reg_addr, .i_reg_wr, .i_reg_rd,
   .i_reg_wdata, .o_reg_rdata,
   .i_core_halted, .i_core_request, .i_drv_disabled, .i_serial_error, .i_clock_missing,
   .i_code_sum_bad_a, .i_code_sum_bad_b, .i_ext_clock_valid, .o_return_to_ext_reference,
   .o_core_alert, .o_clock_drv_enable, .o_host_interrupt_out_n);
`default_nettype wire
